// *** src/cao_core.sv ***
`timescale 1ns/1ps
module cao_core import cao_pkg::*; (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_instr_valid,
   input wire logic [7:0] i_opcode,
   input wire logic [7:0] i_byte2,
   input wire logic [7:0] i_byte3,
   output logic o_instr_ready,
   input wire logic i_load_mem_en,
   input wire logic i_load_reg_en,
   input wire logic i_load_acc_en,
   input wire logic i_load_carry_en,
   input wire logic [7:0] i_load_addr,
   input wire logic [2:0] i_load_reg_sel,
   input wire logic [7:0] i_load_data,
   input wire logic i_load_carry,
   input wire logic [7:0] i_peek_addr,
   output logic [7:0] o_peek_data,
   output logic [15:0] o_pc,
   output logic [7:0] o_accumulator,
   output logic o_carry_flag,
   output logic o_aux_carry_flag,
   output logic o_overflow_flag,
   output logic [63:0] o_working_regs,
   output logic o_unsupported
);
   cao_state_t state;
   logic [2:0] cnt;
   logic [7:0] lat_op;
   logic [7:0] lat_b2;
   logic [7:0] lat_b3;
   logic [7:0][7:0] wregs;
   logic [2:0] in_cycles;
   logic in_take, in_one, in_add_reg, in_anl_reg, in_clr_acc, load_ok, exec;
   logic x_add, x_anl, x_compare_branch_unequal_op, x_pjump, x_bit_and, x_wr, x_ind, x_short;
   logic [7:0] sel_reg, rd_addr, rd_data, opnd, add_b, sum, cj_lhs, cj_rhs;
   logic [7:0] mem_wr_data, mem_wr_addr, wr_result;
   logic add_cin, add_c, add_ac, add_ov, mem_wr_en, bit_val;
   logic [15:0] pc_plus, x_pc_next;

   function automatic logic [2:0] cycles_of(input logic [7:0] op);
      logic [2:0] c;
      c = CYC_NONE;
      if (op[7:3] == GRP_ADD_REG || op[7:3] == GRP_ADD_WITH_CARRY_OP_REG || op[7:3] == GRP_ANL_REG) begin
         c = CYC_ONE;
      end else if (op == OP_CLR_ACC) begin
         c = CYC_ONE;
      end else if (op[7:1] == IND_ADD || op[7:1] == IND_ADD_WITH_CARRY_OP || op[7:1] == IND_ANL) begin
         c = CYC_TWO;
      end else if (op == OP_ADD_DIR || op == OP_ADD_IMM || op == OP_ADD_WITH_CARRY_OP_DIR
                   || op == OP_ADD_WITH_CARRY_OP_IMM || op == OP_ANL_DIR || op == OP_ANL_IMM) begin
         c = CYC_TWO;
      end else if (op == OP_ANL_C_BIT || op == OP_ANL_C_NBIT) begin
         c = CYC_TWO;
      end else if (op == OP_ANL_DIR_ACC || op == OP_ANL_DIR_IMM || op == OP_CLR_BIT) begin
         c = CYC_THREE;
      end else if (op[4:0] == PJ_LOW) begin
         c = CYC_THREE;
      end else if (op == OP_COMPARE_BRANCH_UNEQUAL_OP_IMM || op[7:3] == GRP_COMPARE_BRANCH_UNEQUAL_OP_REG) begin
         c = CYC_FOUR;
      end else if (op == OP_COMPARE_BRANCH_UNEQUAL_OP_DIR || op[7:1] == IND_COMPARE_BRANCH_UNEQUAL_OP) begin
         c = CYC_FIVE;
      end
      return c;
   endfunction

   // byte holding a bit address: RAM bits in 0x20..0x2F, else the 8-aligned byte given by bits 7..3
   function automatic logic [7:0] bit_byte(input logic [7:0] b);
      return b[7] ? {b[7:3], 3'h0} : {BIT_RAM_HI, b[6:3]};
   endfunction

   assign in_cycles = cycles_of(i_opcode);
   assign in_take = o_instr_ready && i_instr_valid;
   assign in_one = (in_cycles <= CYC_ONE);
   assign in_add_reg = (i_opcode[7:3] == GRP_ADD_REG) || (i_opcode[7:3] == GRP_ADD_WITH_CARRY_OP_REG);
   assign in_anl_reg = (i_opcode[7:3] == GRP_ANL_REG);
   assign in_clr_acc = (i_opcode == OP_CLR_ACC);
   assign load_ok = o_instr_ready && !i_instr_valid;
   assign sel_reg = wregs[i_opcode[2:0]];
   assign exec = (state == CAO_EXEC);

   // classes of the latched instruction, valid in its second cycle
   assign x_ind = (lat_op[7:1] == IND_ADD) || (lat_op[7:1] == IND_ADD_WITH_CARRY_OP)
                  || (lat_op[7:1] == IND_ANL);
   assign x_add = exec && ((lat_op[7:1] == IND_ADD) || (lat_op[7:1] == IND_ADD_WITH_CARRY_OP)
                  || lat_op == OP_ADD_DIR || lat_op == OP_ADD_IMM
                  || lat_op == OP_ADD_WITH_CARRY_OP_DIR || lat_op == OP_ADD_WITH_CARRY_OP_IMM);
   assign x_anl = exec && ((lat_op[7:1] == IND_ANL) || lat_op == OP_ANL_DIR
                  || lat_op == OP_ANL_IMM);
   assign x_compare_branch_unequal_op = exec && (lat_op == OP_COMPARE_BRANCH_UNEQUAL_OP_IMM || lat_op == OP_COMPARE_BRANCH_UNEQUAL_OP_DIR
                  || lat_op[7:3] == GRP_COMPARE_BRANCH_UNEQUAL_OP_REG || lat_op[7:1] == IND_COMPARE_BRANCH_UNEQUAL_OP);
   assign x_pjump = exec && (lat_op[4:0] == PJ_LOW);
   assign x_bit_and = exec && (lat_op == OP_ANL_C_BIT || lat_op == OP_ANL_C_NBIT);
   assign x_wr = exec && (lat_op == OP_ANL_DIR_ACC || lat_op == OP_ANL_DIR_IMM
                  || lat_op == OP_CLR_BIT);
   assign x_short = (lat_op == OP_ANL_DIR_IMM) || (lat_op == OP_COMPARE_BRANCH_UNEQUAL_OP_IMM)
                  || (lat_op == OP_COMPARE_BRANCH_UNEQUAL_OP_DIR) || (lat_op[7:3] == GRP_COMPARE_BRANCH_UNEQUAL_OP_REG)
                  || (lat_op[7:1] == IND_COMPARE_BRANCH_UNEQUAL_OP);

   // operand fetch address issued in the accept cycle
   always_comb begin
      if (i_opcode[7:1] == IND_ADD || i_opcode[7:1] == IND_ADD_WITH_CARRY_OP
          || i_opcode[7:1] == IND_ANL || i_opcode[7:1] == IND_COMPARE_BRANCH_UNEQUAL_OP) begin
         rd_addr = wregs[{2'h0, i_opcode[0]}];
      end else if (i_opcode == OP_ANL_C_BIT || i_opcode == OP_ANL_C_NBIT
                   || i_opcode == OP_CLR_BIT) begin
         rd_addr = bit_byte(i_byte2);
      end else begin
         rd_addr = i_byte2;
      end
   end

   cao_ram #(.AW(8), .DW(8)) u_ram (
      .i_clock(i_clock),
      .i_wr_en(mem_wr_en),
      .i_wr_addr(mem_wr_addr),
      .i_wr_data(mem_wr_data),
      .i_rd_addr(rd_addr),
      .o_rd_data(rd_data),
      .i_peek_addr(i_peek_addr),
      .o_peek_data(o_peek_data)
   );

   // immediate forms have opcode low nibble 4
   assign opnd = (lat_op[3:0] == 4'h4) ? lat_b2 : rd_data;
   assign add_b = exec ? opnd : sel_reg;
   assign add_cin = (exec ? lat_op[4] : i_opcode[4]) && o_carry_flag;

   cao_adder u_adder (
      .i_a(o_accumulator),
      .i_b(add_b),
      .i_cin(add_cin),
      .o_sum(sum),
      .o_carry(add_c),
      .o_aux_carry(add_ac),
      .o_overflow(add_ov)
   );

   assign bit_val = rd_data[lat_b2[2:0]];
   assign cj_lhs = (lat_op == OP_COMPARE_BRANCH_UNEQUAL_OP_IMM || lat_op == OP_COMPARE_BRANCH_UNEQUAL_OP_DIR) ? o_accumulator :
                   (lat_op[7:3] == GRP_COMPARE_BRANCH_UNEQUAL_OP_REG) ? wregs[lat_op[2:0]] : rd_data;
   assign cj_rhs = (lat_op == OP_COMPARE_BRANCH_UNEQUAL_OP_DIR) ? rd_data : lat_b2;

   // read-modify-write results
   always_comb begin
      wr_result = rd_data & o_accumulator;
      if (lat_op == OP_ANL_DIR_IMM) begin
         wr_result = rd_data & lat_b3;
      end else if (lat_op == OP_CLR_BIT) begin
         wr_result = rd_data & ~(8'h01 << lat_b2[2:0]);
      end
   end

   assign mem_wr_en = x_wr || (load_ok && i_load_mem_en);
   assign mem_wr_addr = !x_wr ? i_load_addr :
                        (lat_op == OP_CLR_BIT) ? bit_byte(lat_b2) : lat_b2;
   assign mem_wr_data = x_wr ? wr_result : i_load_data;

   // next program counter for multi-cycle instructions
   always_comb begin
      if (x_short) begin
         pc_plus = o_pc + PC_STEP_3;
      end else if (x_ind) begin
         pc_plus = o_pc + PC_STEP_1;
      end else begin
         pc_plus = o_pc + PC_STEP_2;
      end
      x_pc_next = pc_plus;
      if (x_pjump) begin
         x_pc_next = {pc_plus[15:11], lat_op[7:5], lat_b2};
      end else if (x_compare_branch_unequal_op && cj_lhs != cj_rhs) begin
         x_pc_next = pc_plus + {{8{lat_b3[7]}}, lat_b3};
      end
   end

   // sequencing: hold the fetch for the instruction's cycle count
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         state <= CAO_IDLE;
         cnt <= CYC_NONE;
         o_instr_ready <= 1'b1;
      end else begin
         case (state)
            CAO_IDLE: begin
               if (in_take && !in_one) begin
                  state <= CAO_EXEC;
                  cnt <= in_cycles - CYC_ONE;
                  o_instr_ready <= 1'b0;
               end
            end
            default: begin
               if (cnt == CYC_ONE) begin
                  state <= CAO_IDLE;
                  o_instr_ready <= 1'b1;
               end else begin
                  state <= CAO_WAIT;
               end
               cnt <= cnt - CYC_ONE;
            end
         endcase
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         lat_op <= 8'h00;
         lat_b2 <= 8'h00;
         lat_b3 <= 8'h00;
         o_unsupported <= 1'b0;
      end else begin
         if (in_take) begin
            lat_op <= i_opcode;
            lat_b2 <= i_byte2;
            lat_b3 <= i_byte3;
         end
         o_unsupported <= in_take && (in_cycles == CYC_NONE);
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_pc <= PC_RESET;
      end else if (in_take && in_one) begin
         o_pc <= o_pc + PC_STEP_1;
      end else if (exec) begin
         o_pc <= x_pc_next;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_accumulator <= ACC_RESET;
      end else if (in_take && in_one) begin
         if (in_add_reg) begin
            o_accumulator <= sum;
         end else if (in_anl_reg) begin
            o_accumulator <= o_accumulator & sel_reg;
         end else if (in_clr_acc) begin
            o_accumulator <= ACC_RESET;
         end
      end else if (x_add) begin
         o_accumulator <= sum;
      end else if (x_anl) begin
         o_accumulator <= o_accumulator & opnd;
      end else if (load_ok && i_load_acc_en) begin
         o_accumulator <= i_load_data;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_carry_flag <= FLAG_RESET;
         o_aux_carry_flag <= FLAG_RESET;
         o_overflow_flag <= FLAG_RESET;
      end else if ((in_take && in_one && in_add_reg) || x_add) begin
         o_carry_flag <= add_c;
         o_aux_carry_flag <= add_ac;
         o_overflow_flag <= add_ov;
      end else if (x_bit_and) begin
         o_carry_flag <= o_carry_flag && (bit_val ^ (lat_op == OP_ANL_C_NBIT));
      end else if (x_compare_branch_unequal_op) begin
         o_carry_flag <= (cj_lhs < cj_rhs);
      end else if (load_ok && i_load_carry_en) begin
         o_carry_flag <= i_load_carry;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         wregs <= REGS_RESET;
      end else if (load_ok && i_load_reg_en) begin
         wregs[i_load_reg_sel] <= i_load_data;
      end
   end
   assign o_working_regs = wregs;

   // checks
   logic [8:0] chk_sum9;
   logic [7:0] chk_lo7;
   logic [4:0] chk_lo4;
   assign chk_sum9 = {1'b0, o_accumulator} + {1'b0, add_b} + {8'h00, add_cin};
   assign chk_lo7 = {1'b0, o_accumulator[6:0]} + {1'b0, add_b[6:0]} + {7'h00, add_cin};
   assign chk_lo4 = {1'b0, o_accumulator[3:0]} + {1'b0, add_b[3:0]} + {4'h0, add_cin};

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);

   property p_add_reg;
      in_take && in_add_reg |=> o_accumulator == $past(chk_sum9[7:0])
         && o_pc == $past(o_pc) + PC_STEP_1 && o_instr_ready;
   endproperty
   a_add_reg: assert property (p_add_reg) else $error("register add wrong");
   property p_add_carry;
      (in_take && in_one && in_add_reg) || x_add |=> o_carry_flag == $past(chk_sum9[8])
         && o_aux_carry_flag == $past(chk_lo4[4]);
   endproperty
   a_add_carry: assert property (p_add_carry) else $error("add carry wrong");
   property p_add_ov;
      (in_take && in_one && in_add_reg) || x_add |=>
         o_overflow_flag == ($past(chk_lo7[7]) ^ $past(chk_sum9[8]));
   endproperty
   a_add_ov: assert property (p_add_ov) else $error("add overflow wrong");
   property p_add_dir;
      in_take && i_opcode == OP_ADD_DIR |=> !o_instr_ready ##1
         o_instr_ready && o_pc == $past(o_pc, 2) + PC_STEP_2;
   endproperty
   a_add_dir: assert property (p_add_dir) else $error("direct add timing wrong");
   property p_add_ind;
      in_take && i_opcode[7:1] == IND_ADD |=> !o_instr_ready ##1
         o_instr_ready && o_pc == $past(o_pc, 2) + PC_STEP_1;
   endproperty
   a_add_ind: assert property (p_add_ind) else $error("indirect add timing wrong");
   property p_pjump;
      x_pjump |=> o_pc[10:0] == {$past(lat_op[7:5]), $past(lat_b2)}
         && o_pc[15:11] == $past(pc_plus[15:11]);
   endproperty
   a_pjump: assert property (p_pjump) else $error("page jump target wrong");
   property p_anl_flags;
      in_take && in_anl_reg |=> $stable(o_carry_flag) && $stable(o_overflow_flag)
         && $stable(o_aux_carry_flag) && o_accumulator == ($past(o_accumulator) & $past(sel_reg));
   endproperty
   a_anl_flags: assert property (p_anl_flags) else $error("byte and wrong");
   property p_compare_branch_unequal_op;
      x_compare_branch_unequal_op |=> o_carry_flag == ($past(cj_lhs) < $past(cj_rhs)) && o_pc ==
         ($past(cj_lhs) != $past(cj_rhs) ? $past(pc_plus) + {{8{$past(lat_b3[7])}},
         $past(lat_b3)} : $past(pc_plus));
   endproperty
   a_compare_branch_unequal_op: assert property (p_compare_branch_unequal_op) else $error("compare branch wrong");
   property p_compare_branch_unequal_op_five;
      in_take && i_opcode == OP_COMPARE_BRANCH_UNEQUAL_OP_DIR |=> !o_instr_ready [*4] ##1 o_instr_ready;
   endproperty
   a_compare_branch_unequal_op_five: assert property (p_compare_branch_unequal_op_five) else $error("compare direct not 5 cycles");
   property p_clr_acc;
      in_take && i_opcode == OP_CLR_ACC |=> o_accumulator == 8'h00
         && o_pc == $past(o_pc) + PC_STEP_1 && $stable(o_carry_flag);
   endproperty
   a_clr_acc: assert property (p_clr_acc) else $error("clear accumulator wrong");
   property p_clr_bit;
      x_wr && lat_op == OP_CLR_BIT |-> mem_wr_en && !mem_wr_data[lat_b2[2:0]]
         && mem_wr_addr == bit_byte(lat_b2);
   endproperty
   a_clr_bit: assert property (p_clr_bit) else $error("clear bit wrong");

   c_branch_taken: cover property (x_compare_branch_unequal_op && cj_lhs != cj_rhs);
   c_add_overflow: cover property (x_add && add_ov);
   c_back_to_back: cover property (in_take && in_one ##1 in_take && !in_one);
   c_page_jump: cover property (x_pjump);
endmodule // cao_core

// *** src/cao_pkg.sv ***
package cao_pkg;
   // single opcodes
   localparam logic [7:0] OP_ADD_IMM = 8'h24;
   localparam logic [7:0] OP_ADD_DIR = 8'h25;
   localparam logic [7:0] OP_ADD_WITH_CARRY_OP_IMM = 8'h34;
   localparam logic [7:0] OP_ADD_WITH_CARRY_OP_DIR = 8'h35;
   localparam logic [7:0] OP_ANL_DIR_ACC = 8'h52;
   localparam logic [7:0] OP_ANL_DIR_IMM = 8'h53;
   localparam logic [7:0] OP_ANL_IMM = 8'h54;
   localparam logic [7:0] OP_ANL_DIR = 8'h55;
   localparam logic [7:0] OP_ANL_C_BIT = 8'h82;
   localparam logic [7:0] OP_ANL_C_NBIT = 8'hB0;
   localparam logic [7:0] OP_COMPARE_BRANCH_UNEQUAL_OP_IMM = 8'hB4;
   localparam logic [7:0] OP_COMPARE_BRANCH_UNEQUAL_OP_DIR = 8'hB5;
   localparam logic [7:0] OP_CLR_BIT = 8'hC2;
   localparam logic [7:0] OP_CLR_ACC = 8'hE4;
   // working register groups, opcode bits 7..3
   localparam logic [4:0] GRP_ADD_REG = 5'h05;
   localparam logic [4:0] GRP_ADD_WITH_CARRY_OP_REG = 5'h07;
   localparam logic [4:0] GRP_ANL_REG = 5'h0B;
   localparam logic [4:0] GRP_COMPARE_BRANCH_UNEQUAL_OP_REG = 5'h17;
   // pointer register pairs, opcode bits 7..1
   localparam logic [6:0] IND_ADD = 7'h13;
   localparam logic [6:0] IND_ADD_WITH_CARRY_OP = 7'h1B;
   localparam logic [6:0] IND_ANL = 7'h2B;
   localparam logic [6:0] IND_COMPARE_BRANCH_UNEQUAL_OP = 7'h5B;
   // page jump: opcode bits 4..0
   localparam logic [4:0] PJ_LOW = 5'h01;
   // cycle counts
   localparam logic [2:0] CYC_NONE = 3'h0;
   localparam logic [2:0] CYC_ONE = 3'h1;
   localparam logic [2:0] CYC_TWO = 3'h2;
   localparam logic [2:0] CYC_THREE = 3'h3;
   localparam logic [2:0] CYC_FOUR = 3'h4;
   localparam logic [2:0] CYC_FIVE = 3'h5;
   // program counter steps (instruction lengths)
   localparam logic [15:0] PC_STEP_1 = 16'h0001;
   localparam logic [15:0] PC_STEP_2 = 16'h0002;
   localparam logic [15:0] PC_STEP_3 = 16'h0003;
   // bit-addressable RAM base (upper nibble of byte address)
   localparam logic [3:0] BIT_RAM_HI = 4'h2;
   // reset values
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [63:0] REGS_RESET = 64'h0;
   localparam logic FLAG_RESET = 1'b0;
   typedef enum logic [1:0] {CAO_IDLE, CAO_EXEC, CAO_WAIT} cao_state_t;
endpackage

// *** src/cao_adder.sv ***
`timescale 1ns/1ps
module cao_adder (
   input wire logic [7:0] i_a,
   input wire logic [7:0] i_b,
   input wire logic i_cin,
   output logic [7:0] o_sum,
   output logic o_carry,
   output logic o_aux_carry,
   output logic o_overflow
);
   logic [4:0] lo;
   logic [3:0] mid;
   logic [1:0] hi;
   // nibble, bits 6..4 and bit 7 split to expose carries out of bits 3, 6, 7
   assign lo = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, i_cin};
   assign mid = {1'b0, i_a[6:4]} + {1'b0, i_b[6:4]} + {3'h0, lo[4]};
   assign hi = {1'b0, i_a[7]} + {1'b0, i_b[7]} + {1'b0, mid[3]};
   assign o_sum = {hi[0], mid[2:0], lo[3:0]};
   assign o_carry = hi[1];
   assign o_aux_carry = lo[4];
   assign o_overflow = hi[1] ^ mid[3];
endmodule // cao_adder

// *** src/cao_ram.sv ***
`timescale 1ns/1ps
module cao_ram #(
   parameter int AW = 8,
   parameter int DW = 8
) (
   input wire logic i_clock,
   input wire logic i_wr_en,
   input wire logic [AW-1:0] i_wr_addr,
   input wire logic [DW-1:0] i_wr_data,
   input wire logic [AW-1:0] i_rd_addr,
   output logic [DW-1:0] o_rd_data,
   input wire logic [AW-1:0] i_peek_addr,
   output logic [DW-1:0] o_peek_data
);
   logic [DW-1:0] mem [2**AW];

   always_ff @(posedge i_clock) begin
      if (i_wr_en) begin
         mem[i_wr_addr] <= i_wr_data;
      end
   end

   // read data registered; a same-cycle write is not seen
   always_ff @(posedge i_clock) begin
      o_rd_data <= mem[i_rd_addr];
      o_peek_data <= mem[i_peek_addr];
   end
endmodule // cao_ram

// *** tb/cao_core_tb.sv ***
`timescale 1ns/1ps
module cao_core_tb import cao_pkg::*;;
   logic i_clock, i_rst_n, i_instr_valid, o_instr_ready, i_load_mem_en, i_load_reg_en;
   logic i_load_acc_en, i_load_carry_en, i_load_carry, o_carry_flag, o_aux_carry_flag;
   logic o_overflow_flag, o_unsupported;
   logic [7:0] i_opcode, i_byte2, i_byte3, i_load_addr, i_load_data, i_peek_addr;
   logic [7:0] o_peek_data, o_accumulator;
   logic [2:0] i_load_reg_sel;
   logic [15:0] o_pc, pc_exp;
   logic [63:0] o_working_regs;
   int errors, n_compared, cycles, ticks, i;
   logic [7:0] tb_op [4] = '{8'h54, 8'h55, 8'h56, 8'h57};
   logic [7:0] tb_b2 [4] = '{8'hA5, 8'h42, 8'h00, 8'h00};
   logic [7:0] tb_res [4] = '{8'hA5, 8'h3C, 8'h80, 8'h80};

   cao_core cao_core_inst (.i_clock, .i_rst_n, .i_instr_valid, .i_opcode, .i_byte2, .i_byte3,
      .o_instr_ready, .i_load_mem_en, .i_load_reg_en, .i_load_acc_en, .i_load_carry_en,
      .i_load_addr, .i_load_reg_sel, .i_load_data, .i_load_carry, .i_peek_addr, .o_peek_data,
      .o_pc, .o_accumulator, .o_carry_flag, .o_aux_carry_flag, .o_overflow_flag,
      .o_working_regs, .o_unsupported);

   always #25 i_clock = ~i_clock;

   task end_of_test();
      $display("compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   always @(posedge i_clock) begin
      ticks++;
      if (ticks == 5000) begin
         errors++;
         end_of_test();
      end
   end

   task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task flags(input logic [2:0] f);
      chk("flags", {13'h0000, f}, {13'h0000, o_carry_flag, o_aux_carry_flag, o_overflow_flag});
   endtask

   task acc(input logic [7:0] a);
      chk("accumulator", {8'h00, a}, {8'h00, o_accumulator});
   endtask

   // kind bits: ram, register, accumulator, carry
   task load(input logic [3:0] kind, input logic [7:0] addr, input logic [7:0] data);
      @(posedge i_clock);
      {i_load_mem_en, i_load_reg_en, i_load_acc_en, i_load_carry_en} <= kind;
      i_load_addr <= addr;
      i_load_reg_sel <= addr[2:0];
      i_load_data <= data;
      i_load_carry <= data[0];
      @(posedge i_clock);
      {i_load_mem_en, i_load_reg_en, i_load_acc_en, i_load_carry_en} <= 4'h0;
   endtask

   task peek(input logic [7:0] addr, input logic [7:0] exp);
      @(posedge i_clock);
      i_peek_addr <= addr;
      @(posedge i_clock);
      #1;
      chk("ram", {8'h00, exp}, {8'h00, o_peek_data});
   endtask

   // counts edges from the taking edge until ready returns
   task run(input logic [7:0] op, b2, b3, input int cyc, input logic [15:0] pc_new);
      @(posedge i_clock);
      i_instr_valid <= 1'b1;
      i_opcode <= op;
      i_byte2 <= b2;
      i_byte3 <= b3;
      @(posedge i_clock);
      i_instr_valid <= 1'b0;
      cycles = 1;
      #1;
      while (o_instr_ready !== 1'b1 && cycles < 10) begin
         @(posedge i_clock);
         #1;
         cycles++;
      end
      chk("cycles", cyc[15:0], cycles[15:0]);
      chk("pc", pc_new, o_pc);
      pc_exp = pc_new;
   endtask

   function automatic logic [15:0] br(input logic [7:0] rel);
      return pc_exp + PC_STEP_3 + {{8{rel[7]}}, rel};
   endfunction

   // page taken from the counter already past the two jump bytes
   function automatic logic [15:0] pj(input logic [2:0] hi, input logic [7:0] lo);
      logic [15:0] nxt;
      nxt = pc_exp + PC_STEP_2;
      return {nxt[15:11], hi, lo};
   endfunction

   task t_add();
      load(4'h2, 8'h00, 8'h7F);
      load(4'h4, 8'h02, 8'h01);
      run(8'h2A, 8'h00, 8'h00, 1, pc_exp + 16'h0001);
      acc(8'h80);
      flags(3'b011);
      load(4'h8, 8'h40, 8'h80);
      run(8'h25, 8'h40, 8'h00, 2, pc_exp + 16'h0002);
      acc(8'h00);
      flags(3'b101);
      run(8'h24, 8'h0F, 8'h00, 2, pc_exp + 16'h0002);
      acc(8'h0F);
      flags(3'b000);
      load(4'h4, 8'h00, 8'h40);
      load(4'h4, 8'h01, 8'h40);
      run(8'h26, 8'h00, 8'h00, 2, pc_exp + 16'h0001);
      acc(8'h8F);
      run(8'h27, 8'h00, 8'h00, 2, pc_exp + 16'h0001);
      acc(8'h0F);
      flags(3'b101);
      $display("test add done");
   endtask

   task t_add_with_carry_op();
      load(4'h1, 8'h00, 8'h01);
      load(4'h2, 8'h00, 8'h0F);
      load(4'h4, 8'h07, 8'h00);
      run(8'h3F, 8'h00, 8'h00, 1, pc_exp + 16'h0001);
      acc(8'h10);
      flags(3'b010);
      load(4'h1, 8'h00, 8'h01);
      load(4'h2, 8'h00, 8'hFF);
      run(8'h34, 8'h00, 8'h00, 2, pc_exp + 16'h0002);
      acc(8'h00);
      flags(3'b110);
      run(8'h35, 8'h40, 8'h00, 2, pc_exp + 16'h0002);
      acc(8'h81);
      run(8'h36, 8'h00, 8'h00, 2, pc_exp + 16'h0001);
      acc(8'h01);
      flags(3'b101);
      run(8'h37, 8'h00, 8'h00, 2, pc_exp + 16'h0001);
      acc(8'h82);
      $display("test add with carry done");
   endtask

   task t_jump();
      for (i = 0; i < 8; i++) begin
         run({i[2:0], PJ_LOW}, 8'h5A, 8'h00, 3, pj(i[2:0], 8'h5A));
      end
      $display("test page jump done");
   endtask

   task t_and();
      load(4'h1, 8'h00, 8'h01);
      load(4'h2, 8'h00, 8'hF0);
      load(4'h4, 8'h03, 8'h3C);
      load(4'h8, 8'h42, 8'h3C);
      run(8'h5B, 8'h00, 8'h00, 1, pc_exp + 16'h0001);
      acc(8'h30);
      for (i = 0; i < 4; i++) begin
         load(4'h2, 8'h00, 8'hFF);
         run(tb_op[i], tb_b2[i], 8'h00, 2, pc_exp + (i < 2 ? 16'h0002 : 16'h0001));
         acc(tb_res[i]);
      end
      load(4'h8, 8'h41, 8'hC3);
      run(8'h52, 8'h41, 8'h00, 3, pc_exp + 16'h0002);
      peek(8'h41, 8'h80);
      run(8'h53, 8'h41, 8'h7F, 3, pc_exp + 16'h0003);
      peek(8'h41, 8'h00);
      flags(3'b100);
      $display("test and done");
   endtask

   task t_bit();
      load(4'h8, 8'h21, 8'h04);
      load(4'h1, 8'h00, 8'h01);
      run(8'h82, 8'h0A, 8'h00, 2, pc_exp + 16'h0002);
      flags(3'b100);
      run(8'h82, 8'h0B, 8'h00, 2, pc_exp + 16'h0002);
      flags(3'b000);
      load(4'h1, 8'h00, 8'h01);
      run(8'hB0, 8'h0B, 8'h00, 2, pc_exp + 16'h0002);
      flags(3'b100);
      run(8'hB0, 8'h0A, 8'h00, 2, pc_exp + 16'h0002);
      flags(3'b000);
      peek(8'h21, 8'h04);
      run(8'hC2, 8'h0A, 8'h00, 3, pc_exp + 16'h0002);
      peek(8'h21, 8'h00);
      $display("test bit done");
   endtask

   task t_cmp();
      load(4'h1, 8'h00, 8'h01);
      load(4'h2, 8'h00, 8'h10);
      load(4'h4, 8'h05, 8'h30);
      run(8'hB4, 8'h10, 8'h05, 4, pc_exp + 16'h0003);
      flags(3'b000);
      run(8'hB4, 8'h20, 8'hFE, 4, br(8'hFE));
      flags(3'b100);
      run(8'hB5, 8'h40, 8'h04, 5, br(8'h04));
      flags(3'b100);
      run(8'hBD, 8'h20, 8'h10, 4, br(8'h10));
      flags(3'b000);
      run(8'hB6, 8'h80, 8'hF0, 5, pc_exp + 16'h0003);
      run(8'hB7, 8'h7F, 8'h03, 5, br(8'h03));
      flags(3'b000);
      acc(8'h10);
      chk("register", 16'h0030, {8'h00, o_working_regs[47:40]});
      peek(8'h40, 8'h80);
      $display("test compare done");
   endtask

   task t_clr();
      load(4'h1, 8'h00, 8'h01);
      load(4'h2, 8'h00, 8'h5A);
      run(OP_CLR_ACC, 8'h00, 8'h00, 1, pc_exp + 16'h0001);
      acc(8'h00);
      flags(3'b100);
      chk("unsupported", 16'h0000, {15'h0000, o_unsupported});
      run(8'hA5, 8'h00, 8'h00, 1, pc_exp + 16'h0001);
      chk("unsupported", 16'h0001, {15'h0000, o_unsupported});
      acc(8'h00);
      $display("test clear done");
   endtask

   initial begin
      {i_clock, i_rst_n, i_instr_valid, i_load_mem_en, i_load_reg_en} = 5'h00;
      {i_load_acc_en, i_load_carry_en, i_load_carry} = 3'h0;
      {i_opcode, i_byte2, i_byte3, i_load_addr, i_load_data, i_peek_addr} = 48'h0;
      i_load_reg_sel = 3'h0;
      pc_exp = PC_RESET;
      repeat (2) @(posedge i_clock);
      i_rst_n <= 1'b1;
      #1;
      chk("pc", PC_RESET, o_pc);
      acc(ACC_RESET);
      t_add();
      t_add_with_carry_op();
      t_jump();
      t_and();
      t_bit();
      t_cmp();
      t_clr();
      end_of_test();
   end
endmodule // cao_core_tb
